// *** sbw_pkg.sv ***
// package for the wake-up and event logic of the basis chip
// assumes a 50 MHz system clock; analog comparators arrive as clean logic levels
// ==========================================================
package sbw_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int FILT_US = 20;
	localparam int FILT_CYC = (FILT_US * (CLK_HZ / 1_000_000));
	localparam int CS_ON_US = 400;
	localparam int CS_ON_CYC = (CS_ON_US * (CLK_HZ / 1_000_000));
	localparam int CS_SMP_US = 300;
	localparam int CS_SMP_CYC = (CS_SMP_US * (CLK_HZ / 1_000_000));
	localparam int RST_US = 1000;
	localparam int RST_CYC = (RST_US * (CLK_HZ / 1_000_000));
	localparam int CFG_MS = 75;
	localparam int CFG_CYC = (CFG_MS * (CLK_HZ / 1_000));
	localparam int UV_MS = 100;
	localparam int UV_CYC = (UV_MS * (CLK_HZ / 1_000));
	localparam int MS_CYC = (CLK_HZ / 1_000);
	localparam int NUM_WAKE = 3;
	localparam int NUM_IRQ = 8;
	typedef enum logic [1:0] {SBW_OPT_NONE, SBW_OPT_HIGH, SBW_OPT_LOW, SBW_OPT_CHANGE} sbw_opt_t;
	typedef enum logic [1:0] {SBW_VAR_A, SBW_VAR_C, SBW_VAR_D} sbw_var_t;
	typedef enum {SBW_RESET, SBW_CFG_WAIT, SBW_NORMAL, SBW_STANDBY, SBW_SLEEP, SBW_EMERG} sbw_mode_t;
	typedef struct packed {
		logic forced_en;
		logic cyclic_en;
		logic inputs_on_switched_output;
		logic [2:0] period_sel;
	} sbw_switched_output_config_reg_t;
	typedef struct packed {
		logic go_normal;
		logic go_standby;
		logic go_sleep;
		logic go_emergency;
		logic configured;
	} sbw_mode_req_t;
	// period table in milliseconds, index by 3-bit field
	function automatic int sbw_period_ms(input logic [2:0] sel);
		unique case (sel)
			3'h0: sbw_period_ms = 32;
			3'h1: sbw_period_ms = 64;
			3'h2: sbw_period_ms = 128;
			3'h3: sbw_period_ms = 256;
			3'h4: sbw_period_ms = 512;
			3'h5: sbw_period_ms = 1024;
			3'h6: sbw_period_ms = 2048;
			3'h7: sbw_period_ms = 8192;
		endcase
	endfunction
endpackage

// *** sbw_wake_ctrl.sv ***
// top of wake-up, interrupt and reset handling
// assumes mode requests come from serial decode as one-cycle pulses
`timescale 1ns/1ps
module sbw_wake_ctrl #(
	parameter int CFG_CYC = sbw_pkg::CFG_CYC,
	parameter int UV_CYC = sbw_pkg::UV_CYC,
	parameter int MS_CYC = sbw_pkg::MS_CYC,
	parameter int RST_CYC = sbw_pkg::RST_CYC,
	parameter sbw_pkg::sbw_var_t VARIANT = sbw_pkg::SBW_VAR_A
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// configuration
	input wire sbw_pkg::sbw_switched_output_config_reg_t switched_output_config_reg,
	input wire logic [2:0] cyclic_timing_reg,
	input wire sbw_pkg::sbw_opt_t wake_input_option_reg,
	input wire logic [1:0] cyclic_edge_sel,
	input wire logic switched_on_req,
	input wire sbw_pkg::sbw_mode_req_t mode_req,
	// wake inputs and analog status
	input wire logic [2:0] wake_in,
	input wire logic main_regulator_low,
	input wire logic main_regulator_off,
	input wire logic chip_select_n,
	input wire logic can_tx,
	input wire logic [3:0] canh_below_thr,
	input wire logic [1:0] ground_shift_sel,
	input wire logic [7:0] irq_src,
	input wire logic [7:0] irq_mask,
	// software clears
	input wire logic [2:0] wake_status_clr,
	input wire logic spi_wake_clr,
	input wire logic shift_clr,
	input wire logic [7:0] irq_clr,
	// reset pin
	input wire logic reset_pin_n_in,
	output logic reset_pin_n_out,
	output logic reset_pin_n_oe,
	// outputs
	output logic switched_battery_output,
	output logic main_regulator_en,
	output logic [2:0] wake_input_status_reg,
	output logic [2:0] wake_input_live_level_reg,
	output logic [1:0] second_irq_status_reg,
	output logic ground_shift_reg,
	output logic [7:0] irq_status,
	output logic irq_out_n,
	output sbw_pkg::sbw_mode_t mode
);
	// ==========================================================
	// mode and shared signals
	sbw_pkg::sbw_mode_t next_mode;
	logic [22:0] cfg_cnt;
	logic [22:0] uv_cnt;
	logic [15:0] rst_cnt;
	logic [18:0] ms_cnt;
	logic [13:0] per_cnt;
	logic [14:0] on_cnt;
	logic pulse_on;
	logic in_sleep;
	logic sense_ok;
	logic cyclic_act;
	logic forced_act;
	logic [2:0] det;
	logic [2:0] cyc_det;
	logic wake_evt;
	logic cs_wake;
	logic forced_evt;
	logic host_rst_rel;
	logic rst_pin_d;
	logic cs_d;
	logic tx_d;
	logic [13:0] period;

	assign in_sleep = (mode == sbw_pkg::SBW_SLEEP);
	assign cyclic_act = in_sleep && switched_output_config_reg.cyclic_en;
	assign forced_act = in_sleep && switched_output_config_reg.forced_en && !cyclic_act;
	assign period = cyclic_act ? 14'(sbw_pkg::sbw_period_ms(cyclic_timing_reg))
		: 14'(sbw_pkg::sbw_period_ms(switched_output_config_reg.period_sel));
	assign switched_battery_output = in_sleep ? pulse_on :
		((mode == sbw_pkg::SBW_NORMAL || mode == sbw_pkg::SBW_STANDBY) && switched_on_req);
	assign sense_ok = !switched_output_config_reg.inputs_on_switched_output
		|| switched_battery_output;
	assign main_regulator_en = !(in_sleep || mode == sbw_pkg::SBW_EMERG);
	assign reset_pin_n_out = 1'b0;
	assign reset_pin_n_oe = (mode == sbw_pkg::SBW_RESET);
	assign cs_wake = in_sleep && main_regulator_off && cs_d && !chip_select_n;
	assign host_rst_rel = !rst_pin_d && reset_pin_n_in && !reset_pin_n_oe
		&& (mode == sbw_pkg::SBW_NORMAL || mode == sbw_pkg::SBW_STANDBY);
	assign wake_evt = in_sleep && ((switched_output_config_reg.inputs_on_switched_output
		? |cyc_det : |det) || cs_wake || forced_evt);
	assign irq_out_n = !(|(irq_status & irq_mask));

	// ==========================================================
	// mode sequencing
	always_comb begin
		next_mode = mode;
		unique case (mode)
			sbw_pkg::SBW_RESET: begin
				if (VARIANT == sbw_pkg::SBW_VAR_A && uv_cnt >= 23'(UV_CYC))
					next_mode = sbw_pkg::SBW_SLEEP;
				else if (!main_regulator_low && rst_cnt >= 16'(RST_CYC - 1))
					next_mode = sbw_pkg::SBW_CFG_WAIT;
			end
			sbw_pkg::SBW_CFG_WAIT: begin
				if (mode_req.go_emergency)
					next_mode = sbw_pkg::SBW_EMERG;
				else if (mode_req.configured)
					next_mode = sbw_pkg::SBW_NORMAL;
				else if (cfg_cnt >= 23'(CFG_CYC - 1))
					next_mode = sbw_pkg::SBW_SLEEP;
			end
			sbw_pkg::SBW_NORMAL, sbw_pkg::SBW_STANDBY: begin
				if (mode_req.go_emergency)
					next_mode = sbw_pkg::SBW_EMERG;
				else if (mode_req.go_sleep)
					next_mode = sbw_pkg::SBW_SLEEP;
				else if (mode_req.go_standby)
					next_mode = sbw_pkg::SBW_STANDBY;
				else if (mode_req.go_normal)
					next_mode = sbw_pkg::SBW_NORMAL;
				if (host_rst_rel)
					next_mode = sbw_pkg::SBW_CFG_WAIT;
			end
			sbw_pkg::SBW_SLEEP: begin
				if (wake_evt)
					next_mode = sbw_pkg::SBW_RESET;
			end
			sbw_pkg::SBW_EMERG: next_mode = sbw_pkg::SBW_EMERG;
		endcase
		if (main_regulator_low && (mode == sbw_pkg::SBW_CFG_WAIT
			|| mode == sbw_pkg::SBW_NORMAL || mode == sbw_pkg::SBW_STANDBY))
			next_mode = sbw_pkg::SBW_RESET;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			mode <= sbw_pkg::SBW_RESET;
		else
			mode <= next_mode;
	end

	always_ff @(posedge clk_sys) begin
		if (srst || mode != sbw_pkg::SBW_RESET)
			rst_cnt <= '0;
		else if (rst_cnt < 16'(RST_CYC - 1))
			rst_cnt <= rst_cnt + 16'h0001;
	end

	always_ff @(posedge clk_sys) begin
		if (srst || mode != sbw_pkg::SBW_RESET || !main_regulator_low)
			uv_cnt <= '0;
		else if (uv_cnt < 23'(UV_CYC))
			uv_cnt <= uv_cnt + 23'h00_0001;
	end

	always_ff @(posedge clk_sys) begin
		if (srst || mode != sbw_pkg::SBW_CFG_WAIT)
			cfg_cnt <= '0;
		else
			cfg_cnt <= cfg_cnt + 23'h00_0001;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rst_pin_d <= 1'b1;
			cs_d <= 1'b1;
			tx_d <= 1'b1;
		end else begin
			rst_pin_d <= reset_pin_n_in;
			cs_d <= chip_select_n;
			tx_d <= can_tx;
		end
	end

	// ==========================================================
	// sleep timebase for forced wake-up and cyclic pulses
	always_ff @(posedge clk_sys) begin
		if (srst || !(cyclic_act || forced_act)) begin
			ms_cnt <= '0;
			per_cnt <= '0;
			forced_evt <= 1'b0;
		end else begin
			forced_evt <= 1'b0;
			if (ms_cnt >= 19'(MS_CYC - 1)) begin
				ms_cnt <= '0;
				if (per_cnt >= period - 14'h0001) begin
					per_cnt <= '0;
					forced_evt <= forced_act;
				end else
					per_cnt <= per_cnt + 14'h0001;
			end else
				ms_cnt <= ms_cnt + 19'h0_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || !cyclic_act) begin
			on_cnt <= '0;
			pulse_on <= 1'b0;
		end else if (ms_cnt == 19'h0_0000 && per_cnt == 14'h0000 && !pulse_on) begin
			pulse_on <= 1'b1;
			on_cnt <= '0;
		end else if (pulse_on) begin
			on_cnt <= on_cnt + 15'h0001;
			if (on_cnt >= 15'(sbw_pkg::CS_ON_CYC - 1))
				pulse_on <= 1'b0;
		end
	end

	// ==========================================================
	// per-input detection
	for (genvar i = 0; i < sbw_pkg::NUM_WAKE; i++) begin : g_in
		logic [9:0] filt_cnt;
		logic ref_lvl;
		logic [3:0] smp;
		logic [2:0] nsmp;
		logic cond;
		always_comb begin
			unique case (wake_input_option_reg)
				sbw_pkg::SBW_OPT_NONE: cond = 1'b0;
				sbw_pkg::SBW_OPT_HIGH: cond = wake_in[i];
				sbw_pkg::SBW_OPT_LOW: cond = !wake_in[i];
				sbw_pkg::SBW_OPT_CHANGE: cond = (wake_in[i] != ref_lvl);
			endcase
		end
		always_ff @(posedge clk_sys) begin
			if (srst || !cond || !sense_ok || mode == sbw_pkg::SBW_EMERG
				|| mode == sbw_pkg::SBW_CFG_WAIT)
				filt_cnt <= '0;
			else if (filt_cnt <= 10'(sbw_pkg::FILT_CYC))
				filt_cnt <= filt_cnt + 10'h001;
		end
		assign det[i] = (filt_cnt == 10'(sbw_pkg::FILT_CYC)) && (!in_sleep
			|| !switched_output_config_reg.inputs_on_switched_output);
		always_ff @(posedge clk_sys) begin
			if (srst)
				ref_lvl <= 1'b0;
			else if (wake_input_option_reg != sbw_pkg::SBW_OPT_CHANGE || det[i])
				ref_lvl <= wake_in[i];
		end
		always_ff @(posedge clk_sys) begin
			if (srst || !cyclic_act) begin
				smp <= '0;
				nsmp <= '0;
			end else if (pulse_on && on_cnt == 15'(sbw_pkg::CS_SMP_CYC)) begin
				smp <= {smp[2:0], wake_in[i]};
				if (nsmp < 3'h4)
					nsmp <= nsmp + 3'h1;
			end
		end
		// rising 0011, falling 1100, both either
		assign cyc_det[i] = (nsmp == 3'h4) && wake_input_option_reg != sbw_pkg::SBW_OPT_NONE
			&& ((cyclic_edge_sel[0] && smp == 4'h3)
			|| (cyclic_edge_sel[1] && smp == 4'hc));
	end

	// ==========================================================
	// sticky status flags, set wins over clear, and live input levels
	always_ff @(posedge clk_sys) begin
		if (srst)
			wake_input_status_reg <= '0;
		else
			wake_input_status_reg <= (wake_input_status_reg & ~wake_status_clr)
				| det | (cyc_det & {3{in_sleep}});
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			wake_input_live_level_reg <= '0;
		else if (mode == sbw_pkg::SBW_NORMAL || mode == sbw_pkg::SBW_STANDBY)
			wake_input_live_level_reg <= wake_in;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			second_irq_status_reg <= '0;
		else
			second_irq_status_reg <= {second_irq_status_reg[1], second_irq_status_reg[0]
				& !spi_wake_clr} | {1'b0, cs_wake};
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			ground_shift_reg <= 1'b0;
		else if (tx_d && !can_tx && canh_below_thr[ground_shift_sel])
			ground_shift_reg <= 1'b1;
		else if (shift_clr)
			ground_shift_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			irq_status <= '0;
		else if (mode == sbw_pkg::SBW_NORMAL || mode == sbw_pkg::SBW_STANDBY)
			irq_status <= (irq_status & ~irq_clr) | irq_src
				| {1'b0, |det, 6'h00};
		else
			irq_status <= irq_status & ~irq_clr;
	end

	// ==========================================================
	// checks
	a_emerg_sticky: assert property (@(posedge clk_sys) disable iff (srst)
		mode == sbw_pkg::SBW_EMERG |=> mode == sbw_pkg::SBW_EMERG)
		else $error("emergency left");
	a_cyc_over_forced: assert property (@(posedge clk_sys) disable iff (srst)
		cyclic_act |-> !forced_act)
		else $error("forced active with cyclic");
	a_none_no_flag: assert property (@(posedge clk_sys) disable iff (srst)
		wake_input_option_reg == sbw_pkg::SBW_OPT_NONE |-> det == 3'h0)
		else $error("wake seen with option none");
	a_reset_pin_low: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(reset_pin_n_oe) && !main_regulator_low |-> reset_pin_n_oe [*8])
		else $error("reset pulse too short");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (srst)
		wake_input_status_reg[0] && !wake_status_clr[0] |=> wake_input_status_reg[0])
		else $error("wake flag lost");
	a_cs_wake_flag: assert property (@(posedge clk_sys) disable iff (srst)
		cs_wake |=> second_irq_status_reg[0] && mode == sbw_pkg::SBW_RESET)
		else $error("chip select wake missed");
	a_shift_set: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(can_tx) && canh_below_thr[ground_shift_sel] |=> ground_shift_reg)
		else $error("shift bit not set");
	a_irq_mask: assert property (@(posedge clk_sys) disable iff (srst)
		!irq_out_n |-> |(irq_status & irq_mask))
		else $error("interrupt without unmasked source");
	a_uv_holds: assert property (@(posedge clk_sys) disable iff (srst)
		main_regulator_low && mode == sbw_pkg::SBW_NORMAL |=> mode == sbw_pkg::SBW_RESET)
		else $error("undervoltage did not reset");
	a_pulse_off_wake: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(pulse_on) && cyclic_act |-> $past(on_cnt) == 15'(sbw_pkg::CS_ON_CYC - 1))
		else $error("pulse width wrong");
	a_host_release: assert property (@(posedge clk_sys) disable iff (srst)
		host_rst_rel && !main_regulator_low |=> mode == sbw_pkg::SBW_CFG_WAIT)
		else $error("host reset release missed");
	a_forced_wake: assert property (@(posedge clk_sys) disable iff (srst)
		forced_evt && in_sleep |=> mode == sbw_pkg::SBW_RESET)
		else $error("forced wake-up missed");
	a_sleep_wake: assert property (@(posedge clk_sys) disable iff (srst)
		in_sleep && (|det) |=> mode == sbw_pkg::SBW_RESET
		&& (wake_input_status_reg & $past(det)) == $past(det))
		else $error("local wake in sleep missed");
endmodule

// *** sbw_host_model.sv ***
// host side of the reset line: open-drain wire with pull-up
// assumes the chip pulls low through reset_pin_n_oe
`timescale 1ns/1ps
module sbw_host_model (
	// chip side of the pin
	input wire logic reset_pin_n_out,
	input wire logic reset_pin_n_oe,
	// host side
	input wire logic host_pull,
	output logic reset_line
);
	// ==========================================================
	// wired level, pull-up when nobody drives
	always_comb begin
		reset_line = (reset_pin_n_oe ? reset_pin_n_out : 1'b1) & ~host_pull;
	end
endmodule

// *** tb.sv ***
// self-checking bench for the wake-up and event block
// assumes shortened ms, config, undervoltage and reset counts
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	// ==========================================================
	// stimulus and wiring
	logic clk_sys = 0;
	logic srst = 1;
	sbw_pkg::sbw_switched_output_config_reg_t cfg = '0;
	sbw_pkg::sbw_opt_t opt = sbw_pkg::SBW_OPT_NONE;
	sbw_pkg::sbw_mode_req_t mreq = '0;
	sbw_pkg::sbw_mode_t mode;
	logic [2:0] wake_in = '0, wclr = '0, wst, live;
	logic reg_off = 0, cs_n = 1, can_tx = 1, sclr = 0, oe, rout, rst_line, sbo, gs, irq_n;
	logic reg_low = 0, son = 0, hpull = 0, sclr2 = 0, ren;
	logic [2:0] ctr = '0;
	logic [1:0] esel = 2'h3;
	logic [3:0] thr = '0;
	logic [1:0] gsel = '0, st2;
	logic [7:0] isrc = '0, imask = '0, iclr = '0, ist;
	int fail_count = 0;
	int compares = 0;
	int n, ch;
	always #10 clk_sys = ~clk_sys;
	sbw_wake_ctrl #(.CFG_CYC(200), .UV_CYC(300), .MS_CYC(650), .RST_CYC(500)) u_sbw_wake_ctrl (
		.clk_sys(clk_sys), .srst(srst), .switched_output_config_reg(cfg),
		.cyclic_timing_reg(ctr), .wake_input_option_reg(opt), .cyclic_edge_sel(esel),
		.switched_on_req(son), .mode_req(mreq), .wake_in(wake_in),
		.main_regulator_low(reg_low), .main_regulator_off(reg_off), .chip_select_n(cs_n),
		.can_tx(can_tx), .canh_below_thr(thr), .ground_shift_sel(gsel), .irq_src(isrc),
		.irq_mask(imask), .wake_status_clr(wclr), .spi_wake_clr(sclr2), .shift_clr(sclr),
		.irq_clr(iclr), .reset_pin_n_in(rst_line), .reset_pin_n_out(rout),
		.reset_pin_n_oe(oe), .switched_battery_output(sbo), .main_regulator_en(ren),
		.wake_input_status_reg(wst), .wake_input_live_level_reg(live),
		.second_irq_status_reg(st2), .ground_shift_reg(gs), .irq_status(ist),
		.irq_out_n(irq_n), .mode(mode));
	sbw_host_model u_sbw_host_model (.reset_pin_n_out(rout), .reset_pin_n_oe(oe),
		.host_pull(hpull), .reset_line(rst_line));
	// ==========================================================
	// helpers
	task automatic step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_mode(input sbw_pkg::sbw_mode_t m, input int lim);
		int i;
		i = 0;
		while (mode !== m && i < lim) begin
			step(1);
			i++;
		end
		`CHK(mode, m)
		if (mode !== m) print_verdict();
	endtask
	task automatic clear_all();
		wclr = 3'h7;
		iclr = 8'hff;
		sclr = 1;
		step(1);
		wclr = '0;
		iclr = '0;
		sclr = 0;
		step(2);
	endtask
	function automatic logic [2:0] idle_of(input sbw_pkg::sbw_opt_t o);
		return (o == sbw_pkg::SBW_OPT_LOW) ? 3'h7 : 3'h0;
	endfunction
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(65));
		step(4);
		srst = 0;
		step(2);
		`CHK(rst_line, 1'b0)
		n = 0;
		while (oe === 1'b1 && n < 60000) begin
			step(1);
			n++;
		end
		`CHK(n > 490 && n < 510, 1'b1)
		wait_mode(sbw_pkg::SBW_CFG_WAIT, 20);
		mreq.configured = 1;
		step(1);
		mreq = '0;
		wait_mode(sbw_pkg::SBW_NORMAL, 20);
		$display("test reset done");
		imask = 8'hff;
		for (int o = 0; o < 3; o++) begin
			opt = sbw_pkg::sbw_opt_t'(o);
			ch = $urandom % 3;
			wake_in = idle_of(opt);
			step(5);
			clear_all();
			wake_in[ch] = ~wake_in[ch];
			step(500);
			`CHK(live, wake_in)
			wake_in = idle_of(opt);
			step(10);
			`CHK(wst, 3'h0)
			wake_in[ch] = ~wake_in[ch];
			step(1100);
			`CHK(wst, (o == 0) ? 3'h0 : 3'(1 << ch))
			`CHK(irq_n, (o == 0))
			wake_in = idle_of(opt);
			step(20);
			`CHK(wst, (o == 0) ? 3'h0 : 3'(1 << ch))
		end
		wake_in = 3'($urandom);
		step(2);
		opt = sbw_pkg::SBW_OPT_CHANGE;
		step(5);
		clear_all();
		step(1100);
		`CHK(wst, 3'h0)
		wake_in[ch] = ~wake_in[ch];
		step(1100);
		`CHK(wst, 3'(1 << ch))
		$display("test options done");
		imask = 8'($urandom);
		for (int i = 0; i < 8; i++) begin
			clear_all();
			isrc = 8'(1 << i);
			step(3);
			isrc = '0;
			step(2);
			`CHK(ist[i], 1'b1)
			`CHK(irq_n, ~imask[i])
		end
		for (int i = 0; i < 8; i++) begin
			clear_all();
			gsel = 2'($urandom);
			thr = 4'($urandom);
			step(2);
			can_tx = 0;
			step(2);
			`CHK(gs, thr[gsel])
			thr = ~thr;
			can_tx = 1;
			step(2);
			`CHK(gs, ~thr[gsel])
		end
		$display("test irq and shift done");
		opt = sbw_pkg::SBW_OPT_HIGH;
		wake_in = '0;
		cfg.inputs_on_switched_output = 1;
		clear_all();
		wake_in[ch] = 1;
		step(1100);
		`CHK(wst, 3'h0)
		son = 1;
		step(1100);
		`CHK(sbo, 1'b1)
		`CHK(wst, 3'(1 << ch))
		wake_in = '0;
		son = 0;
		hpull = 1;
		step(3);
		hpull = 0;
		step(2);
		`CHK(mode, sbw_pkg::SBW_CFG_WAIT)
		mreq.configured = 1;
		step(1);
		mreq = '0;
		wait_mode(sbw_pkg::SBW_NORMAL, 5);
		`CHK(ren, 1'b1)
		cfg = '{forced_en: 1'b1, cyclic_en: 1'b0, inputs_on_switched_output: 1'b0,
			period_sel: 3'h0};
		reg_low = 1;
		step(2);
		`CHK(mode, sbw_pkg::SBW_RESET)
		`CHK(rst_line, 1'b0)
		n = 0;
		while (mode === sbw_pkg::SBW_RESET && n < 400) begin
			step(1);
			n++;
		end
		`CHK(n > 295 && n < 305, 1'b1)
		reg_low = 0;
		`CHK(mode, sbw_pkg::SBW_SLEEP)
		`CHK(ren, 1'b0)
		n = 0;
		while (mode === sbw_pkg::SBW_SLEEP && n < 25000) begin
			step(1);
			n++;
		end
		`CHK(n > 20790 && n < 20810, 1'b1)
		`CHK(mode, sbw_pkg::SBW_RESET)
		wait_mode(sbw_pkg::SBW_CFG_WAIT, 600);
		`CHK(ren, 1'b1)
		mreq.configured = 1;
		step(1);
		mreq = '0;
		wait_mode(sbw_pkg::SBW_NORMAL, 5);
		$display("test forced and undervoltage done");
		opt = sbw_pkg::SBW_OPT_HIGH;
		wake_in = '0;
		clear_all();
		cfg = '{forced_en: 1'b1, cyclic_en: 1'b1, inputs_on_switched_output: 1'b0,
			period_sel: 3'h0};
		ctr = 3'($urandom);
		mreq.go_sleep = 1;
		step(1);
		mreq = '0;
		wait_mode(sbw_pkg::SBW_SLEEP, 5);
		n = 0;
		while (sbo !== 1'b1 && n < 22000) begin
			step(1);
			n++;
		end
		n = 0;
		while (sbo === 1'b1 && n < 25000) begin
			step(1);
			n++;
		end
		`CHK(n, 20000)
		step(2000);
		`CHK(mode, sbw_pkg::SBW_SLEEP)
		cs_n = 0;
		step(3);
		cs_n = 1;
		step(3);
		`CHK(mode, sbw_pkg::SBW_SLEEP)
		reg_off = 1;
		step(3);
		cs_n = 0;
		step(3);
		`CHK(st2, 2'h1)
		`CHK(mode, sbw_pkg::SBW_RESET)
		cs_n = 1;
		reg_off = 0;
		cfg = '0;
		sclr2 = 1;
		step(1);
		sclr2 = 0;
		step(1);
		`CHK(st2, 2'h0)
		wait_mode(sbw_pkg::SBW_CFG_WAIT, 600);
		step(150);
		`CHK(mode, sbw_pkg::SBW_CFG_WAIT)
		wait_mode(sbw_pkg::SBW_SLEEP, 100);
		clear_all();
		wake_in[ch] = 1;
		step(1100);
		`CHK(wst, 3'(1 << ch))
		`CHK(mode, sbw_pkg::SBW_RESET)
		wait_mode(sbw_pkg::SBW_CFG_WAIT, 600);
		mreq.go_emergency = 1;
		step(1);
		mreq = '0;
		wait_mode(sbw_pkg::SBW_EMERG, 5);
		clear_all();
		wake_in = ~wake_in;
		step(1100);
		`CHK(wst, 3'h0)
		`CHK(mode, sbw_pkg::SBW_EMERG)
		`CHK(ren, 1'b0)
		$display("test sleep done");
		print_verdict();
	end
endmodule
